// ==== rtl/pbc_pkg.sv ====
// Package: register map, field layout and encodings of the photodiode bias bank
package pbc_pkg;

	// Register addresses on the serial register port
	localparam logic [7:0] PBC_ADDR_BIAS_PWR   = 8'h3c;
	localparam logic [7:0] PBC_ADDR_STATE_BIAS = 8'h54;

	// Reset values, reserved fields at their documented patterns
	localparam logic [15:0] PBC_RST_BIAS_PWR   = 16'h3006;
	localparam logic [15:0] PBC_RST_STATE_BIAS = 16'h0020;

	// afe_global_bias_power fields
	localparam int unsigned PBC_DEF_SEL_BIT = 9;
	localparam int unsigned PBC_PD_HI       = 8;
	localparam int unsigned PBC_PD_LO       = 3;

	// per_state_bias_and_integration fields
	localparam int unsigned PBC_B_SINGLE_BIT = 15;
	localparam int unsigned PBC_A_SINGLE_BIT = 14;
	localparam int unsigned PBC_SLEEP_HI     = 13;
	localparam int unsigned PBC_SLEEP_LO     = 12;
	localparam int unsigned PBC_B_CODE_HI    = 11;
	localparam int unsigned PBC_B_CODE_LO    = 10;
	localparam int unsigned PBC_A_CODE_HI    = 9;
	localparam int unsigned PBC_A_CODE_LO    = 8;
	localparam int unsigned PBC_OVR_BIT      = 7;

	// Channel count and channel_shutdown_mask layout (field-relative)
	localparam int unsigned PBC_CHANNELS   = 4;
	localparam int unsigned PBC_CH1_PD_BIT = 0;
	localparam int unsigned PBC_CH2_PD_BIT = 3;

	// Sequencer state as seen by the bank
	typedef enum logic [1:0] {
		PBC_SEQ_IDLE   = 2'b00,
		PBC_SEQ_SLEEP  = 2'b01,
		PBC_SEQ_SLOT_A = 2'b10,
		PBC_SEQ_SLOT_B = 2'b11
	} pbc_seq_t;

	// Bias level select; equals the two-bit per-state code
	typedef enum logic [1:0] {
		PBC_LV_1V8  = 2'b00,
		PBC_LV_1V3  = 2'b01,
		PBC_LV_1V55 = 2'b10,
		PBC_LV_0V0  = 2'b11
	} pbc_level_t;

endpackage

// ==== rtl/pbc_bias_decode.sv ====
// Combinational cathode and anode bias selection from state and settings
`timescale 1ns/100ps
`default_nettype none
module pbc_bias_decode
	import pbc_pkg::*;
(
	input  wire logic [1:0] seq_state,    // Current sequencer state
	input  wire logic       override,     // per_state_bias_override
	input  wire logic       default_sel,  // Single default bias selector
	input  wire logic [1:0] sleep_code,   // Sleep bias code
	input  wire logic [1:0] slot_a_code,  // slot_a_bias_code
	input  wire logic [1:0] slot_b_code,  // slot_b_bias_code
	output logic [1:0]      cathode,      // Cathode level select
	output logic [1:0]      anode,        // Anode level select
	output logic            fwd_bias      // Cathode below anode in a slot
);

	logic [1:0] dflt;

	always_comb begin
		dflt     = default_sel ? PBC_LV_1V8 : PBC_LV_1V3;
		cathode  = dflt;
		anode    = PBC_LV_1V3;
		fwd_bias = 1'b0;
		case (seq_state)
			PBC_SEQ_SLEEP: begin
				if (override) begin
					cathode = sleep_code;
					anode   = sleep_code;
				end
			end
			PBC_SEQ_SLOT_A: begin
				if (override) begin
					cathode = slot_a_code;
				end
				anode    = PBC_LV_1V3;
				fwd_bias = (cathode == PBC_LV_0V0);
			end
			PBC_SEQ_SLOT_B: begin
				if (override) begin
					cathode = slot_b_code;
				end
				anode    = PBC_LV_1V3;
				fwd_bias = (cathode == PBC_LV_0V0);
			end
			default: begin
				// In the idle state the per-state codes do not apply
				cathode = dflt;
				anode   = PBC_LV_1V3;
			end
		endcase
	end

endmodule
`default_nettype wire

// ==== rtl/pbc_top.sv ====
// Photodiode bias and channel configuration bank with registered controls
`timescale 1ns/100ps
`default_nettype none
module pbc_top
	import pbc_pkg::*;
(
	input  wire logic        clk,          // 125 MHz system clock
	input  wire logic        rst,          // Asynchronous reset, active high
	input  wire logic        ce,           // Clock enable, freezes all state
	input  wire logic [7:0]  reg_addr,     // Register address
	input  wire logic [15:0] reg_wdata,    // Write data
	input  wire logic        reg_wr,       // Write strobe
	input  wire logic        reg_rd,       // Read strobe
	input  wire logic [1:0]  seq_state,    // Sequencer state
	output logic [15:0]      reg_rdata_q,  // Read data
	output logic             reg_rvalid_q, // Read data valid pulse
	output logic [1:0]       cathode_q,    // Cathode level select
	output logic [1:0]       anode_q,      // Anode level select
	output logic             fwd_bias_q,   // Forward bias warning
	output logic [3:0]       chan_pd_q,    // Per-channel power-down
	output logic [3:0]       integ_en_q    // Per-channel integration enable
);

	// Configuration registers
	logic [15:0] bias_pwr_q;
	logic [15:0] bias_pwr_d;
	logic [15:0] state_bias_q;
	logic [15:0] state_bias_d;

	// Read port
	logic [15:0] reg_rdata_d;
	logic        reg_rvalid_d;

	// Control outputs
	logic [1:0] cathode_d;
	logic [1:0] anode_d;
	logic       fwd_bias_d;
	logic [3:0] chan_pd_d;
	logic [3:0] integ_en_d;

	// Decoded fields
	logic [5:0] shutdown_mask;
	logic       override;
	logic       a_single;
	logic       b_single;
	logic       in_slot_a;
	logic       in_slot_b;
	logic [1:0] cathode_now;
	logic [1:0] anode_now;
	logic       fwd_now;

	assign shutdown_mask = bias_pwr_q[PBC_PD_HI:PBC_PD_LO];
	assign override      = state_bias_q[PBC_OVR_BIT];
	assign a_single      = state_bias_q[PBC_A_SINGLE_BIT];
	assign b_single      = state_bias_q[PBC_B_SINGLE_BIT];
	assign in_slot_a     = (seq_state == PBC_SEQ_SLOT_A);
	assign in_slot_b     = (seq_state == PBC_SEQ_SLOT_B);

	// Register writes and reads
	always_comb begin
		bias_pwr_d   = bias_pwr_q;
		state_bias_d = state_bias_q;
		reg_rdata_d  = reg_rdata_q;
		reg_rvalid_d = 1'b0;
		if (reg_wr) begin
			// Every bit stored, reserved ones included, so readback matches
			case (reg_addr)
				PBC_ADDR_BIAS_PWR:   bias_pwr_d = reg_wdata;
				PBC_ADDR_STATE_BIAS: state_bias_d = reg_wdata;
				default: begin
				end
			endcase
		end
		if (reg_rd) begin
			reg_rvalid_d = 1'b1;
			case (reg_addr)
				PBC_ADDR_BIAS_PWR:   reg_rdata_d = bias_pwr_q;
				PBC_ADDR_STATE_BIAS: reg_rdata_d = state_bias_q;
				default:             reg_rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bias_pwr_q   <= PBC_RST_BIAS_PWR;
			state_bias_q <= PBC_RST_STATE_BIAS;
			reg_rdata_q  <= 16'h0000;
			reg_rvalid_q <= 1'b0;
		end else if (ce) begin
			bias_pwr_q   <= bias_pwr_d;
			state_bias_q <= state_bias_d;
			reg_rdata_q  <= reg_rdata_d;
			reg_rvalid_q <= reg_rvalid_d;
		end
	end

	// Bias level selection
	pbc_bias_decode u_bias (
		.seq_state   (seq_state),
		.override    (override),
		.default_sel (bias_pwr_q[PBC_DEF_SEL_BIT]),
		.sleep_code  (state_bias_q[PBC_SLEEP_HI:PBC_SLEEP_LO]),
		.slot_a_code (state_bias_q[PBC_A_CODE_HI:PBC_A_CODE_LO]),
		.slot_b_code (state_bias_q[PBC_B_CODE_HI:PBC_B_CODE_LO]),
		.cathode     (cathode_now),
		.anode       (anode_now),
		.fwd_bias    (fwd_now)
	);

	// Per-channel power-down and integration enable
	genvar ch;
	generate
		for (ch = 0; ch < PBC_CHANNELS; ch++) begin : g_chan
			if (ch == 0) begin : g_first
				always_comb begin
					chan_pd_d[ch]  = shutdown_mask[PBC_CH1_PD_BIT];
					// Channel one integrates in either slot mode
					integ_en_d[ch] = (in_slot_a || in_slot_b) && !chan_pd_d[ch];
				end
			end else begin : g_rest
				always_comb begin
					chan_pd_d[ch]  = shutdown_mask[PBC_CH2_PD_BIT + ch - 1];
					integ_en_d[ch] = ((in_slot_a && !a_single) ||
						(in_slot_b && !b_single)) && !chan_pd_d[ch];
				end
			end
		end
	endgenerate

	always_comb begin
		cathode_d  = cathode_now;
		anode_d    = anode_now;
		fwd_bias_d = fwd_now;
	end

	// Outputs follow the settings one edge later, so they never glitch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cathode_q  <= PBC_LV_1V3;
			anode_q    <= PBC_LV_1V3;
			fwd_bias_q <= 1'b0;
			chan_pd_q  <= 4'h0;
			integ_en_q <= 4'h0;
		end else if (ce) begin
			cathode_q  <= cathode_d;
			anode_q    <= anode_d;
			fwd_bias_q <= fwd_bias_d;
			chan_pd_q  <= chan_pd_d;
			integ_en_q <= integ_en_d;
		end
	end

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence ovr_set_s;
		ce && reg_wr && reg_addr == PBC_ADDR_STATE_BIAS && reg_wdata[PBC_OVR_BIT];
	endsequence

	sequence in_slot_a_s;
		ce && !reg_wr && seq_state == PBC_SEQ_SLOT_A;
	endsequence

	default_bias_a: assert property (
		(ce && !override && seq_state != PBC_SEQ_SLEEP) |=>
		cathode_q == ($past(bias_pwr_q[PBC_DEF_SEL_BIT]) ? PBC_LV_1V8 : PBC_LV_1V3)
	) else $error("default bias selector misdecoded");

	shutdown_map_a: assert property (
		ce |=> chan_pd_q[3:1] == $past(shutdown_mask[5:3])
			&& chan_pd_q[0] == $past(shutdown_mask[0])
	) else $error("channel power-down does not follow mask");

	slot_b_single_a: assert property (
		(ce && in_slot_b && b_single) |=> integ_en_q[3:1] == 3'b000
	) else $error("slot B single-channel mode left other channels on");

	slot_a_all_a: assert property (
		(ce && in_slot_a && !a_single) |=> integ_en_q == ~chan_pd_q
	) else $error("slot A did not use all powered channels");

	sleep_cathode_a: assert property (
		(ce && seq_state == PBC_SEQ_SLEEP && override) |=>
		cathode_q == $past(state_bias_q[PBC_SLEEP_HI:PBC_SLEEP_LO])
	) else $error("sleep code not applied to cathode");

	sleep_anode_a: assert property (
		(ce && seq_state == PBC_SEQ_SLEEP && override) |=> anode_q == cathode_q
	) else $error("sleep anode differs from cathode");

	zero_code_a: assert property (
		(ce && in_slot_b && override
			&& state_bias_q[PBC_B_CODE_HI:PBC_B_CODE_LO] == PBC_LV_0V0) |=>
		cathode_q == PBC_LV_0V0 && fwd_bias_q
	) else $error("zero volt code not flagged as forward bias");

	slot_b_code_a: assert property (
		(ce && in_slot_b && override) |=>
		cathode_q == $past(state_bias_q[PBC_B_CODE_HI:PBC_B_CODE_LO])
	) else $error("slot B code not applied");

	slot_a_code_a: assert property (
		(ce && in_slot_a && override) |=>
		cathode_q == $past(state_bias_q[PBC_A_CODE_HI:PBC_A_CODE_LO])
	) else $error("slot A code not applied");

	slot_anode_a: assert property (
		(ce && (in_slot_a || in_slot_b)) |=> anode_q == PBC_LV_1V3
	) else $error("anode not at 1.3 V during a slot");

	override_swap_a: assert property (
		ovr_set_s ##1 in_slot_a_s |=>
		cathode_q == $past(state_bias_q[PBC_A_CODE_HI:PBC_A_CODE_LO])
	) else $error("override write did not select per-state code");

	readback_a: assert property (
		(ce && reg_wr && reg_addr == PBC_ADDR_BIAS_PWR) ##1
		(ce && !reg_wr && reg_rd && reg_addr == PBC_ADDR_BIAS_PWR) |=>
		reg_rvalid_q && reg_rdata_q == $past(reg_wdata, 2)
	) else $error("register readback differs from last write");

	unmapped_read_a: assert property (
		(ce && reg_rd && reg_addr != PBC_ADDR_BIAS_PWR
			&& reg_addr != PBC_ADDR_STATE_BIAS) |=>
		reg_rvalid_q && reg_rdata_q == 16'h0000
	) else $error("unmapped read not zero");

	// Port handshake, clock enable freeze, states outside the per-state codes, slot channel use and slot A zero code
	read_valid_a: assert property (
		(ce && reg_rd) |=> reg_rvalid_q
	) else $error("read strobe gave no valid pulse");

	valid_pulse_a: assert property (
		(ce && !reg_rd) |=> !reg_rvalid_q
	) else $error("read valid held past one cycle");

	freeze_regs_a: assert property (
		!ce |=> $stable(bias_pwr_q) && $stable(state_bias_q)
			&& $stable(reg_rdata_q) && $stable(reg_rvalid_q)
	) else $error("registers moved while clock enable low");

	freeze_outs_a: assert property (
		!ce |=> $stable(cathode_q) && $stable(anode_q) && $stable(fwd_bias_q)
			&& $stable(chan_pd_q) && $stable(integ_en_q)
	) else $error("control outputs moved while clock enable low");

	unmapped_write_a: assert property (
		(ce && reg_wr && reg_addr != PBC_ADDR_BIAS_PWR
			&& reg_addr != PBC_ADDR_STATE_BIAS) |=>
		$stable(bias_pwr_q) && $stable(state_bias_q)
	) else $error("unmapped write changed a register");

	idle_bias_a: assert property (
		(ce && seq_state == PBC_SEQ_IDLE) |=>
		cathode_q == ($past(bias_pwr_q[PBC_DEF_SEL_BIT]) ? PBC_LV_1V8 : PBC_LV_1V3)
			&& anode_q == PBC_LV_1V3 && !fwd_bias_q && integ_en_q == 4'h0
	) else $error("idle state bias or integration wrong");

	sleep_default_a: assert property (
		(ce && seq_state == PBC_SEQ_SLEEP && !override) |=>
		anode_q == PBC_LV_1V3 && !fwd_bias_q && integ_en_q == 4'h0
	) else $error("sleep without override changed anode or integration");

	chan_one_used_a: assert property (
		(ce && (in_slot_a || in_slot_b)
			&& !shutdown_mask[PBC_CH1_PD_BIT]) |=>
		integ_en_q[0]
	) else $error("channel one not integrating in a slot");

	pd_no_integ_a: assert property (
		ce |=> (integ_en_q & chan_pd_q) == 4'h0
	) else $error("powered-down channel still integrating");

	slot_b_all_a: assert property (
		(ce && in_slot_b && !b_single) |=> integ_en_q == ~chan_pd_q
	) else $error("slot B did not use all powered channels");

	slot_a_single_a: assert property (
		(ce && in_slot_a && a_single) |=> integ_en_q[3:1] == 3'b000
	) else $error("slot A single-channel mode left other channels on");

	slot_a_zero_a: assert property (
		(ce && in_slot_a && override
			&& state_bias_q[PBC_A_CODE_HI:PBC_A_CODE_LO] == PBC_LV_0V0) |=>
		cathode_q == PBC_LV_0V0 && fwd_bias_q
	) else $error("slot A zero volt code not flagged as forward bias");

endmodule
`default_nettype wire

// ==== bench/pbc_top_tb_top.sv ====
// Self-checking testbench for the photodiode bias and channel configuration bank
`timescale 1ns/100ps
`default_nettype none
module pbc_top_tb_top
	import pbc_pkg::*;
;
	logic        clk;
	logic        rst;
	logic        ce;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [1:0]  seq_state;
	logic [15:0] reg_rdata_q;
	logic        reg_rvalid_q;
	logic [1:0]  cathode_q;
	logic [1:0]  anode_q;
	logic        fwd_bias_q;
	logic [3:0]  chan_pd_q;
	logic [3:0]  integ_en_q;
	logic [1:0]  s;
	logic [1:0]  a;
	logic [1:0]  b;
	int          n_fail;
	int          n_tests;

	pbc_top i_dut (
		.clk          (clk),
		.rst          (rst),
		.ce           (ce),
		.reg_addr     (reg_addr),
		.reg_wdata    (reg_wdata),
		.reg_wr       (reg_wr),
		.reg_rd       (reg_rd),
		.seq_state    (seq_state),
		.reg_rdata_q  (reg_rdata_q),
		.reg_rvalid_q (reg_rvalid_q),
		.cathode_q    (cathode_q),
		.anode_q      (anode_q),
		.fwd_bias_q   (fwd_bias_q),
		.chan_pd_q    (chan_pd_q),
		.integ_en_q   (integ_en_q)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic cmp_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cmp_lv(input string nm, input logic [1:0] e, input logic [1:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic cmp_ch(input string nm, input logic [3:0] e, input logic [3:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask

	// Inputs change on the falling edge, one request every two cycles
	task automatic wr(input logic [7:0] ad, input logic [15:0] d);
		reg_addr = ad;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		// Idle cycle so back-to-back calls never re-drive the strobe in one step
		@(negedge clk);
	endtask

	// Read valid stands for one cycle after the taking edge, read data until the next read
	task automatic rd(input logic [7:0] ad, input logic [15:0] e);
		reg_addr = ad;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		cmp_reg("rvalid", 16'h0001, {15'h0000, reg_rvalid_q});
		cmp_reg("rdata", e, reg_rdata_q);
		@(negedge clk);
	endtask

	// Two edges cover the register update plus the output stage
	task automatic chk(input logic [1:0] st, input logic [1:0] cat, input logic [1:0] an,
		input logic fw, input logic [3:0] pd, input logic [3:0] ie);
		seq_state = st;
		repeat (2) @(negedge clk);
		cmp_lv("cathode", cat, cathode_q);
		cmp_lv("anode", an, anode_q);
		cmp_ch("fwd_bias", {3'b000, fw}, {3'b000, fwd_bias_q});
		cmp_ch("chan_pd", pd, chan_pd_q);
		cmp_ch("integ_en", ie, integ_en_q);
	endtask

	initial begin
		#20000;
		n_fail++;
		conclude();
	end

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		seq_state = PBC_SEQ_IDLE;
		n_fail = 0;
		n_tests = 0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		rd(PBC_ADDR_BIAS_PWR, 16'h3006);
		rd(PBC_ADDR_STATE_BIAS, 16'h0020);
		chk(PBC_SEQ_IDLE, 2'b01, 2'b01, 1'b0, 4'h0, 4'h0);
		wr(PBC_ADDR_BIAS_PWR, 16'h3206);
		rd(PBC_ADDR_BIAS_PWR, 16'h3206);
		chk(PBC_SEQ_IDLE, 2'b00, 2'b01, 1'b0, 4'h0, 4'h0);
		chk(PBC_SEQ_SLEEP, 2'b00, 2'b01, 1'b0, 4'h0, 4'h0);
		chk(PBC_SEQ_SLOT_A, 2'b00, 2'b01, 1'b0, 4'h0, 4'hf);
		wr(PBC_ADDR_BIAS_PWR, 16'h31c6);
		chk(PBC_SEQ_SLOT_B, 2'b01, 2'b01, 1'b0, 4'he, 4'h1);
		// Channel one alone powered down leaves the other three integrating
		wr(PBC_ADDR_BIAS_PWR, 16'h300e);
		chk(PBC_SEQ_SLOT_B, 2'b01, 2'b01, 1'b0, 4'h1, 4'he);
		wr(PBC_ADDR_BIAS_PWR, 16'h3206);
		wr(PBC_ADDR_STATE_BIAS, 16'h4020);
		chk(PBC_SEQ_SLOT_A, 2'b00, 2'b01, 1'b0, 4'h0, 4'h1);
		chk(PBC_SEQ_SLOT_B, 2'b00, 2'b01, 1'b0, 4'h0, 4'hf);
		wr(PBC_ADDR_STATE_BIAS, 16'h8020);
		chk(PBC_SEQ_SLOT_B, 2'b00, 2'b01, 1'b0, 4'h0, 4'h1);
		chk(PBC_SEQ_SLOT_A, 2'b00, 2'b01, 1'b0, 4'h0, 4'hf);
		// Each state gets a different code so a swapped field shows up
		for (int c = 0; c < 4; c++) begin
			s = c[1:0];
			b = s + 2'd1;
			a = s + 2'd2;
			wr(PBC_ADDR_STATE_BIAS, {2'b00, s, b, a, 8'ha0});
			rd(PBC_ADDR_STATE_BIAS, {2'b00, s, b, a, 8'ha0});
			chk(PBC_SEQ_SLEEP, s, s, 1'b0, 4'h0, 4'h0);
			chk(PBC_SEQ_SLOT_B, b, 2'b01, b == 2'd3, 4'h0, 4'hf);
			chk(PBC_SEQ_SLOT_A, a, 2'b01, a == 2'd3, 4'h0, 4'hf);
		end
		wr(PBC_ADDR_STATE_BIAS, 16'h3f20);
		chk(PBC_SEQ_SLEEP, 2'b00, 2'b01, 1'b0, 4'h0, 4'h0);
		chk(PBC_SEQ_SLOT_A, 2'b00, 2'b01, 1'b0, 4'h0, 4'hf);
		// Override set while slot A runs swaps the default for the slot A code
		wr(PBC_ADDR_STATE_BIAS, 16'h02a0);
		chk(PBC_SEQ_SLOT_A, 2'b10, 2'b01, 1'b0, 4'h0, 4'hf);
		// Unmapped place reads zero and swallows writes
		wr(8'h55, 16'hffff);
		rd(8'h55, 16'h0000);
		rd(PBC_ADDR_STATE_BIAS, 16'h02a0);
		// Frozen clock enable must drop the write
		ce = 1'b0;
		wr(PBC_ADDR_BIAS_PWR, 16'h0000);
		ce = 1'b1;
		rd(PBC_ADDR_BIAS_PWR, 16'h3206);
		conclude();
	end
endmodule
`default_nettype wire
